// file: tvs_consts.svh
// Constants of the temperature and voltage converter command decoder.
// Operation
// - Power mode 00 is shutdown, 01 standby with the reference buffer on, 10 standby, 11 normal.
// - Select codes 0000 to 0100 pick inputs 0 to 4 against the common input, 0110 common against itself, 1000 input 0 against 1, 1001 input 2 against 3, 1011 supply/4 against ground.
// - Select codes 0111, 1100 and 1101 are temperature modes with the internal, first external and second external diode.
// - A temperature conversion runs a low bias step, a high bias step, each at gain twenty, and then subtracts the two results.
// - The temperature result is in kelvin with one step equal to one eighth of a degree.
// - A temperature conversion takes 2.2 ms, and the device stays busy for that whole time.
// - Temperature conversions always use the internal reference.
// - A configuration byte carries the power mode and a reference bit, one meaning internal and zero external.
// - The conversion strobe goes low after the last bit of the conversion byte and returns high when the conversion completes.
// - A temperature result goes out as two bytes, first bit first, two extraneous bits, twelve result bits, then two zeros.
`ifndef TVS_CONSTS_SVH
`define TVS_CONSTS_SVH
`define TVS_CLK_PERIOD_NS   50
`define TVS_TEMP_TIME_NS    2200000
`define TVS_VOLT_TIME_NS    1100000
`define TVS_TEMP_CYCLES     (`TVS_TEMP_TIME_NS / `TVS_CLK_PERIOD_NS)
`define TVS_VOLT_CYCLES     (`TVS_VOLT_TIME_NS / `TVS_CLK_PERIOD_NS)
`define TVS_CFG_TAG         4'h0
`define TVS_CONV_TAG        3'h2
`define TVS_PM_SHUTDOWN     2'h0
`define TVS_PM_STANDBY_PLUS 2'h1
`define TVS_PM_STANDBY      2'h2
`define TVS_PM_NORMAL       2'h3
`define TVS_SEL_INT_DIODE   4'h7
`define TVS_SEL_EXT_DIODE1  4'hc
`define TVS_SEL_EXT_DIODE2  4'hd
`define TVS_BIAS_OFF        2'h0
`define TVS_BIAS_LOW        2'h1
`define TVS_BIAS_HIGH       2'h2
`define TVS_RST_PM          2'h0
`define TVS_RST_REF         1'h1
`define TVS_RST_SEL         4'h0
`endif

// file: tvs_pkg.sv
// Types shared by the converter command decoder files.
package tvs_pkg;
	typedef logic [1:0] tvs_pm_t;
	typedef logic [1:0] tvs_bias_t;
	typedef logic [3:0] tvs_sel_t;
	typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_SUB, ST_VOLT} tvs_state_t;
endpackage

// file: tvs_link.sv
// Serial link end of the converter: byte receiver and result shifter on the host clock.
`timescale 1ns/1ps
`include "tvs_consts.svh"
module tvs_link
(
	input  wire logic        sclk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        cs_n_i,
	input  wire logic        din_i,
	input  wire logic [15:0] word_i,
	input  wire logic        word_tgl_i,
	output logic      [7:0]  byte_o,
	output logic             byte_tgl_o,
	output logic             dout_o
);
	import tvs_pkg::*;
	////////////////////////////////////////////////////////////////////////////////
	logic       hunt_reg;
	logic [2:0] cnt_reg;
	logic [6:0] shift_reg;
	logic       rst_s1_reg;
	logic       rst_s2_reg;
	logic       w_s1_reg;
	logic       w_s2_reg;
	logic       w_seen_reg;
	logic [15:0] tx_reg;
	wire        last_bit = !hunt_reg && (cnt_reg == 3'h7);
	wire        new_word = (w_s2_reg != w_seen_reg);
	////////////////////////////////////////////////////////////////////////////////
	// A high select clears the frame at once: the clock stops between frames, so a cut byte
	// would otherwise shift the next one.
	always_ff @(posedge sclk_i or posedge cs_n_i)
	begin
		if (cs_n_i)
		begin
			hunt_reg <= 1'b1;
			cnt_reg  <= 3'h0;
		end
		else if (hunt_reg)
		begin
			hunt_reg <= !din_i;
			cnt_reg  <= 3'h1;
			shift_reg <= 7'h01;
		end
		else
		begin
			shift_reg <= {shift_reg[5:0], din_i};
			cnt_reg   <= cnt_reg + 3'h1;
			hunt_reg  <= last_bit;
		end
	end
	// The byte stays stable until the next toggle, so the core may read it after syncing.
	always_ff @(posedge sclk_i)
	begin
		if (rst_s2_reg)
		begin
			byte_o     <= 8'h00;
			byte_tgl_o <= 1'b0;
		end
		else if (!cs_n_i && last_bit)
		begin
			byte_o     <= {shift_reg, din_i};
			byte_tgl_o <= !byte_tgl_o;
		end
	end
	always_ff @(posedge sclk_i)
	begin
		rst_s1_reg <= sys_rst_i;
		rst_s2_reg <= rst_s1_reg;
	end
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(negedge sclk_i)
	begin
		w_s1_reg <= word_tgl_i;
		w_s2_reg <= w_s1_reg;
	end
	// Zeros fill from the bottom, so shifts past the sixteenth bit give zeros.
	always_ff @(negedge sclk_i)
	begin
		if (rst_s2_reg)
		begin
			w_seen_reg <= 1'b0;
			tx_reg     <= 16'h0000;
			dout_o     <= 1'b0;
		end
		else if (new_word)
		begin
			w_seen_reg <= w_s2_reg;
			dout_o     <= word_i[15];
			tx_reg     <= {word_i[14:0], 1'b0};
		end
		else if (!cs_n_i)
		begin
			dout_o <= tx_reg[15];
			tx_reg <= {tx_reg[14:0], 1'b0};
		end
	end
endmodule

// file: tvs_top.sv
// Command decoder and conversion sequencer of the temperature and voltage converter.
`timescale 1ns/1ps
`include "tvs_consts.svh"
module tvs_top
#(
	parameter int TEMP_CYC = `TVS_TEMP_CYCLES,
	parameter int VOLT_CYC = `TVS_VOLT_CYCLES
)
(
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             sclk_i,
	input  wire logic             cs_n_i,
	input  wire logic             din_i,
	input  wire logic [12:0]      adc_data_i,
	output logic                  dout_o,
	output logic                  conversion_strobe_o,
	output tvs_pkg::tvs_pm_t      power_mode_o,
	output logic                  ref_internal_o,
	output tvs_pkg::tvs_sel_t     input_select_o,
	output logic                  temp_mode_o,
	output tvs_pkg::tvs_bias_t    bias_step_o,
	output logic [15:0]           result_o
);
	import tvs_pkg::*;
	////////////////////////////////////////////////////////////////////////////////
	logic [7:0]  byte_w;
	logic        byte_tgl_w;
	logic        b_s1_reg;
	logic        b_s2_reg;
	logic        b_seen_reg;
	tvs_state_t  state_reg;
	logic [15:0] cnt_reg;
	tvs_pm_t     pm_reg;
	logic        ref_reg;
	logic [11:0] low_reg;
	logic [11:0] high_reg;
	logic        word_tgl_reg;
	logic        strobe_reg;
	tvs_sel_t    sel_reg;
	logic        temp_reg;
	tvs_bias_t   bias_reg;
	logic [15:0] word_reg;
	////////////////////////////////////////////////////////////////////////////////
	tvs_link u_link
	(
		.sclk_i     (sclk_i),
		.sys_rst_i  (sys_rst_i),
		.cs_n_i     (cs_n_i),
		.din_i      (din_i),
		.word_i     (word_reg),
		.word_tgl_i (word_tgl_reg),
		.byte_o     (byte_w),
		.byte_tgl_o (byte_tgl_w),
		.dout_o     (dout_o)
	);
	////////////////////////////////////////////////////////////////////////////////
	wire         new_byte  = (b_s2_reg != b_seen_reg);
	wire         idle      = (state_reg == ST_IDLE);
	wire         cfg_hit   = new_byte && idle && (byte_w[6:3] == `TVS_CFG_TAG);
	wire         conv_hit  = new_byte && idle && (byte_w[6:4] == `TVS_CONV_TAG);
	wire [3:0]   new_sel   = byte_w[3:0];
	wire         temp_code = (new_sel == `TVS_SEL_INT_DIODE) ||
	                         (new_sel == `TVS_SEL_EXT_DIODE1) ||
	                         (new_sel == `TVS_SEL_EXT_DIODE2);
	wire         cnt_done  = (cnt_reg == 16'h0000);
	wire [11:0]  diff      = high_reg - low_reg;
	wire [15:0]  low_len   = 16'(TEMP_CYC / 2 - 1);
	wire [15:0]  high_len  = 16'(TEMP_CYC - TEMP_CYC / 2 - 2);
	wire [15:0]  volt_len  = 16'(VOLT_CYC - 1);
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i)
	begin
		b_s1_reg <= byte_tgl_w;
		b_s2_reg <= b_s1_reg;
	end
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			b_seen_reg <= 1'b0;
		else
			b_seen_reg <= b_s2_reg;
	end
	// Configuration bytes are ignored while a conversion runs.
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			pm_reg  <= `TVS_RST_PM;
			ref_reg <= `TVS_RST_REF;
		end
		else if (cfg_hit)
		begin
			pm_reg  <= byte_w[2:1];
			ref_reg <= byte_w[0];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Unassigned select codes run as a voltage conversion; the result is whatever the
	// converter returns for that routing.
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			state_reg    <= ST_IDLE;
			cnt_reg      <= 16'h0000;
			strobe_reg   <= 1'b1;
			sel_reg      <= `TVS_RST_SEL;
			temp_reg     <= 1'b0;
			bias_reg     <= `TVS_BIAS_OFF;
			low_reg      <= 12'h000;
			high_reg     <= 12'h000;
			word_reg     <= 16'h0000;
			word_tgl_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
			ST_IDLE:
			begin
				if (conv_hit)
				begin
					sel_reg    <= new_sel;
					strobe_reg <= 1'b0;
					temp_reg   <= temp_code;
					if (temp_code)
					begin
						state_reg <= ST_LOW;
						bias_reg  <= `TVS_BIAS_LOW;
						cnt_reg   <= low_len;
					end
					else
					begin
						state_reg <= ST_VOLT;
						cnt_reg   <= volt_len;
					end
				end
				else if (pm_reg == `TVS_PM_SHUTDOWN)
					word_reg <= 16'h0000;
			end
			ST_LOW:
			begin
				cnt_reg <= cnt_reg - 16'h0001;
				if (cnt_done)
				begin
					low_reg   <= adc_data_i[11:0];
					bias_reg  <= `TVS_BIAS_HIGH;
					cnt_reg   <= high_len;
					state_reg <= ST_HIGH;
				end
			end
			ST_HIGH:
			begin
				cnt_reg <= cnt_reg - 16'h0001;
				if (cnt_done)
				begin
					high_reg  <= adc_data_i[11:0];
					bias_reg  <= `TVS_BIAS_OFF;
					state_reg <= ST_SUB;
				end
			end
			ST_SUB:
			begin
				// The difference is already in eighths of a kelvin; no scaling is applied.
				word_reg     <= {{2{diff[11]}}, diff, 2'b00};
				word_tgl_reg <= !word_tgl_reg;
				strobe_reg   <= 1'b1;
				temp_reg     <= 1'b0;
				state_reg    <= ST_IDLE;
			end
			ST_VOLT:
			begin
				cnt_reg <= cnt_reg - 16'h0001;
				if (cnt_done)
				begin
					word_reg     <= {adc_data_i[12], adc_data_i, 2'b00};
					word_tgl_reg <= !word_tgl_reg;
					strobe_reg   <= 1'b1;
					state_reg    <= ST_IDLE;
				end
			end
			default:
				state_reg <= ST_IDLE;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	assign conversion_strobe_o = strobe_reg;
	assign power_mode_o        = pm_reg;
	assign input_select_o      = sel_reg;
	assign temp_mode_o         = temp_reg;
	assign bias_step_o         = bias_reg;
	assign result_o            = word_reg;
	// Held in a flip-flop so that the reference line changes with the mode flag.
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			ref_internal_o <= `TVS_RST_REF;
		else
			ref_internal_o <= (conv_hit && temp_code) || (temp_reg && !(state_reg == ST_SUB)) ||
			                  (cfg_hit ? byte_w[0] : ref_reg);
	end
	////////////////////////////////////////////////////////////////////////////////
	localparam int TEMP_CYC_I = TEMP_CYC;
	logic [16:0] busy_cnt_reg;
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i || strobe_reg)
			busy_cnt_reg <= 17'h00000;
		else
			busy_cnt_reg <= busy_cnt_reg + 17'h00001;
	end
	property p_cfg_mode;
		@(posedge clk_i) disable iff (sys_rst_i)
		cfg_hit |=> (power_mode_o == $past(byte_w[2:1])) && (ref_reg == $past(byte_w[0]));
	endproperty
	a_cfg_mode: assert property (p_cfg_mode) else $error("config byte not applied");
	property p_route;
		@(posedge clk_i) disable iff (sys_rst_i)
		conv_hit |=> input_select_o == $past(byte_w[3:0]);
	endproperty
	a_route: assert property (p_route) else $error("select code not routed");
	property p_temp_mode;
		@(posedge clk_i) disable iff (sys_rst_i)
		conv_hit && temp_code |=> temp_mode_o && bias_step_o == `TVS_BIAS_LOW;
	endproperty
	a_temp_mode: assert property (p_temp_mode) else $error("temperature mode missed");
	property p_step_order;
		@(posedge clk_i) disable iff (sys_rst_i)
		(state_reg == ST_LOW) && cnt_done |=> bias_step_o == `TVS_BIAS_HIGH ##1
		(bias_step_o == `TVS_BIAS_HIGH || state_reg == ST_SUB);
	endproperty
	a_step_order: assert property (p_step_order) else $error("bias steps out of order");
	property p_result;
		@(posedge clk_i) disable iff (sys_rst_i)
		state_reg == ST_SUB |=> result_o[13:2] == $past(diff) && result_o[1:0] == 2'b00 &&
		result_o[15:14] == {2{result_o[13]}};
	endproperty
	a_result: assert property (p_result) else $error("temperature word wrong");
	property p_temp_time;
		@(posedge clk_i) disable iff (sys_rst_i)
		(state_reg == ST_SUB) |=> conversion_strobe_o && $past(busy_cnt_reg) == 17'(TEMP_CYC_I - 1);
	endproperty
	a_temp_time: assert property (p_temp_time) else $error("temperature busy time wrong");
	property p_int_ref;
		@(posedge clk_i) disable iff (sys_rst_i)
		temp_mode_o && $past(temp_mode_o) |-> ref_internal_o;
	endproperty
	a_int_ref: assert property (p_int_ref) else $error("external reference in temperature mode");
	property p_strobe;
		@(posedge clk_i) disable iff (sys_rst_i)
		conv_hit |=> !conversion_strobe_o ##1 !conversion_strobe_o;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe did not fall");
endmodule

// file: tvs_host_model.sv
// Host side serial master model that drives the converter link.
`timescale 1ns/1ps
`include "tvs_consts.svh"
module tvs_host_model
(
	input  wire logic dout_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      din_o
);
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		din_o  = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// The link clock stands still between frames, so each frame makes its own edges.
	task automatic tick;
		#3 sclk_o = 1'b1;
		#3 sclk_o = 1'b0;
	endtask
	// The link end needs a few edges to see reset, so these run with no chip select.
	task automatic idle_clocks(input int n);
		cs_n_o = 1'b1;
		repeat (n) tick();
	endtask
	task automatic send_byte(input logic [7:0] b);
		cs_n_o = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			din_o = b[i];
			tick();
		end
		#3 cs_n_o = 1'b1;
		din_o = ~din_o;
	endtask
	task automatic send_cfg(input logic [1:0] pm, input logic ref_int);
		send_byte({1'b1, `TVS_CFG_TAG, pm, ref_int});
	endtask
	// Callers pass assigned select codes only.
	task automatic send_conv(input logic [3:0] sel);
		send_byte({1'b1, `TVS_CONV_TAG, sel});
	endtask
	// Three dummy falling edges come first: the link syncs the word toggle through two flops and loads the word on the third.
	task automatic read_word(output logic [16:0] w);
		cs_n_o = 1'b0;
		din_o  = 1'b0;
		repeat (3) tick();
		for (int i = 16; i >= 0; i--)
		begin
			#3 sclk_o = 1'b1;
			w[i] = dout_i;
			#3 sclk_o = 1'b0;
		end
		#3 cs_n_o = 1'b1;
		din_o = 1'b1;
	endtask
	function automatic int to_centi_celsius(input logic [11:0] k8);
		return int'(k8) * 100 / 8 - 27315;
	endfunction
endmodule

// file: tvs_top_tb_top.sv
// Self-checking testbench of the converter command decoder.
`timescale 1ns/1ps
`include "tvs_consts.svh"
`define CHK(nm, e, g) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
		end \
	end
module tvs_top_tb_top;
	import tvs_pkg::*;
	localparam int TEMP_CYC = 40;
	localparam int VOLT_CYC = 20;
	logic        clk_i      = 1'b0;
	logic        sys_rst_i  = 1'b1;
	logic [12:0] adc_data_i = 13'h0000;
	logic [12:0] lo_val     = 13'h0100;
	logic [12:0] hi_val     = 13'h0a50;
	logic [16:0] ser;
	wire [11:0]  tdiff      = 12'(hi_val - lo_val);
	tvs_sel_t    tsel [3]   = '{4'h7, 4'hc, 4'hd};
	tvs_sel_t    vsel [9]   = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'hb};
	wire         sclk;
	wire         cs_n;
	wire         din;
	wire         dout_o;
	wire         conversion_strobe_o;
	wire         ref_internal_o;
	wire         temp_mode_o;
	tvs_pm_t     power_mode_o;
	tvs_sel_t    input_select_o;
	tvs_bias_t   bias_step_o;
	logic [15:0] result_o;
	int          n_mismatch   = 0;
	int          total_checks = 0;
	always #25 clk_i = ~clk_i;
	// Low and high bias samples differ so a swapped subtraction shows.
	always @(posedge clk_i)
		adc_data_i <= #2 (bias_step_o == `TVS_BIAS_HIGH) ? hi_val : lo_val;
	tvs_top #(.TEMP_CYC(TEMP_CYC), .VOLT_CYC(VOLT_CYC)) u_tvs_top
	(
		.clk_i              (clk_i),
		.sys_rst_i          (sys_rst_i),
		.sclk_i             (sclk),
		.cs_n_i             (cs_n),
		.din_i              (din),
		.adc_data_i         (adc_data_i),
		.dout_o             (dout_o),
		.conversion_strobe_o(conversion_strobe_o),
		.power_mode_o       (power_mode_o),
		.ref_internal_o     (ref_internal_o),
		.input_select_o     (input_select_o),
		.temp_mode_o        (temp_mode_o),
		.bias_step_o        (bias_step_o),
		.result_o           (result_o)
	);
	tvs_host_model u_tvs_host_model
	(
		.dout_i(dout_o),
		.sclk_o(sclk),
		.cs_n_o(cs_n),
		.din_o (din)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic convert(input tvs_sel_t sel, input int cyc, input logic [15:0] exp);
		int n;
		int n_b1;
		int n_b2;
		n = 0;
		n_b1 = 0;
		n_b2 = 0;
		u_tvs_host_model.send_conv(sel);
		while (conversion_strobe_o !== 1'b0 && n < 20)
		begin
			@(posedge clk_i);
			#2;
			n++;
		end
		n = 0;
		while (conversion_strobe_o === 1'b0 && n < 1000)
		begin
			if (n == 0)
			begin
				`CHK("select", sel, input_select_o)
				`CHK("temp_mode", cyc == TEMP_CYC, temp_mode_o)
				`CHK("ref_internal", cyc == TEMP_CYC, ref_internal_o)
			end
			n_b1 += (bias_step_o === `TVS_BIAS_LOW);
			n_b2 += (bias_step_o === `TVS_BIAS_HIGH);
			n++;
			@(posedge clk_i);
			#2;
		end
		`CHK("strobe_low_cycles", cyc, n)
		`CHK("low_bias_cycles", (cyc == TEMP_CYC) ? TEMP_CYC / 2 : 0, n_b1)
		`CHK("high_bias_cycles", (cyc == TEMP_CYC) ? TEMP_CYC - TEMP_CYC / 2 - 1 : 0, n_b2)
		`CHK("result", exp, result_o)
		repeat (2) @(posedge clk_i);
		u_tvs_host_model.read_word(ser);
		`CHK("serial_word", {exp, 1'b0}, ser)
		repeat (4) @(posedge clk_i);
		#2;
		$display("Test conversion %0h done", sel);
	endtask
	initial
	begin
		repeat (5000) @(posedge clk_i);
		n_mismatch++;
		$display("MISMATCH watchdog expected end seen hang");
		tally_and_finish();
	end
	initial
	begin
		u_tvs_host_model.idle_clocks(4);
		repeat (5) @(posedge clk_i);
		#2;
		`CHK("reset_outputs", {4'h9, 7'h00, 17'h00000}, {conversion_strobe_o, power_mode_o, ref_internal_o, input_select_o, temp_mode_o, bias_step_o, result_o, dout_o})
		sys_rst_i = 1'b0;
		u_tvs_host_model.idle_clocks(4);
		for (int pm = 0; pm < 4; pm++)
		begin
			u_tvs_host_model.send_cfg(2'(pm), ~pm[0]);
			repeat (8) @(posedge clk_i);
			#2;
			`CHK("power_mode", 2'(pm), power_mode_o)
			`CHK("ref_select", ~pm[0], ref_internal_o)
		end
		$display("Test configuration done");
		// The reference select now says external, so temperature must override it.
		for (int i = 0; i < 3; i++)
			convert(tsel[i], TEMP_CYC, {{2{tdiff[11]}}, tdiff, 2'b00});
		`CHK("celsius_x100", 2485, u_tvs_host_model.to_centi_celsius(ser[14:3]))
		lo_val = 13'h1a55;
		for (int i = 0; i < 9; i++)
			convert(vsel[i], VOLT_CYC, {lo_val[12], lo_val, 2'b00});
		u_tvs_host_model.send_cfg(`TVS_PM_SHUTDOWN, 1'b0);
		repeat (8) @(posedge clk_i);
		#2;
		`CHK("result_shutdown", 16'h0000, result_o)
		$display("Test shutdown done");
		tally_and_finish();
	end
endmodule
